// ===== logic/abmc_ctrl.sv
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ns
`include "abmc_regs.svh"
// Notes on behaviour
// - lockout select resets to zero, giving the low 2.7 V driver lockout level
// - lockout select bit 3 set picks the higher 5.4 V driver lockout level
// - amplifier disable resets to zero, error amplifier stays enabled
// - amplifier disable bit 1 set disables amplifier and parks output low
// - digital test enable bit 7 connects digital test mux to test pin
// - select bits 6-4 pick one of seven digital signals, code 7 none
// - analog test enable bit 0 connects analog mux to test pin
// - bit 2 of enable register reads zero, writes ignored
// - role bits 7-6: 00 alone, 01 master, 10 slave, 11 reserved
// - stand-alone role never connects second reference buffer to a pin
// - route bit 5: zero internal feedback resistor, one external sense pin
// - analog test signals observed on test pin via buffer, chosen elsewhere
// - with both enables set the digital signal owns the test pin
// - analog enable clear routes analog signal to internal converter input
// - master role routes second reference to its dedicated pin
module abmc_ctrl
  import abmc_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic CLK_EN_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic SAT_DETECT_I,
  input wire logic MONO_PULSE_I,
  input wire logic OSC_PULSE_I,
  input wire logic TIMER_TWO_PERIOD_MATCH_I,
  input wire logic EXCESS_VOLTAGE_COMPARE_OUT_I,
  input wire logic SWITCHING_FREQUENCY_SIGNAL_I,
  input wire logic SECONDARY_DRIVE_PULSE_ONESHOT_I,
  output logic DRIVER_LOCKOUT_HIGH_O,
  output logic ERROR_AMP_DISABLE_O,
  output logic TEST_PIN_DIG_SEL_O,
  output logic TEST_PIN_DIG_O,
  output logic TEST_PIN_ANA_SEL_O,
  output logic ANA_TO_ADC_SEL_O,
  output logic [1:0] DEVICE_ROLE_O,
  output logic ROLE_RESERVED_O,
  output logic REF2_TO_PIN_O,
  output logic FEEDBACK_TO_EXT_PIN_O
);

  logic [7:0] abe_reg;
  logic [7:0] role_reg;
  abmc_digital_test_select_e digital_test_select;
  abmc_role_e role;
  logic dig_mux;

  // one write decode shared by both registers
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    return a == idx;
  endfunction : hit

  // enable register; unused bit 2 masked so it never stores
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      abe_reg <= `ABMC_RESET_VAL;
    end else if (CLK_EN_I && WR_I && hit(ADDR_I, `ABMC_ADDR_ABE)) begin
      abe_reg <= WDATA_I & `ABMC_ABE_WMASK;
    end
  end

  // role register; low five bits are unimplemented
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      role_reg <= `ABMC_RESET_VAL;
    end else if (CLK_EN_I && WR_I && hit(ADDR_I, `ABMC_ADDR_ROLE)) begin
      role_reg <= WDATA_I & `ABMC_ROLE_WMASK;
    end
  end

  // read data only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      RDATA_O <= `ABMC_RESET_VAL;
    end else if (CLK_EN_I) begin
      if (RD_I && hit(ADDR_I, `ABMC_ADDR_ABE)) begin
        RDATA_O <= abe_reg;
      end else if (RD_I && hit(ADDR_I, `ABMC_ADDR_ROLE)) begin
        RDATA_O <= role_reg;
      end else begin
        RDATA_O <= `ABMC_RESET_VAL;
      end
    end
  end

  assign digital_test_select = abmc_digital_test_select_e'(abe_reg[`ABMC_ABE_DIGITAL_TEST_SELECT_HI:`ABMC_ABE_DIGITAL_TEST_SELECT_LO]);
  assign role = abmc_role_e'(role_reg[`ABMC_ROLE_HI:`ABMC_ROLE_LO]);

  // digital test mux; code 7 drives a quiet low
  always_comb begin
    unique case (digital_test_select)
      ABMC_DIGITAL_TEST_SELECT_SAT: dig_mux = SAT_DETECT_I;
      ABMC_DIGITAL_TEST_SELECT_MONO: dig_mux = MONO_PULSE_I;
      ABMC_DIGITAL_TEST_SELECT_OSC: dig_mux = OSC_PULSE_I;
      ABMC_DIGITAL_TEST_SELECT_TMR2: dig_mux = TIMER_TWO_PERIOD_MATCH_I;
      ABMC_DIGITAL_TEST_SELECT_OV: dig_mux = EXCESS_VOLTAGE_COMPARE_OUT_I;
      ABMC_DIGITAL_TEST_SELECT_SWITCHING_FREQUENCY_SIGNAL: dig_mux = SWITCHING_FREQUENCY_SIGNAL_I;
      ABMC_DIGITAL_TEST_SELECT_SHOT: dig_mux = SECONDARY_DRIVE_PULSE_ONESHOT_I;
      ABMC_DIGITAL_TEST_SELECT_NONE: dig_mux = 1'b0;
    endcase
  end

  // analog control levels come straight off the register bits
  assign DRIVER_LOCKOUT_HIGH_O = abe_reg[`ABMC_ABE_UVLO_SEL];
  assign ERROR_AMP_DISABLE_O = abe_reg[`ABMC_ABE_EA_DIS];

  // test pin steering; digital has priority over analog
  assign TEST_PIN_DIG_SEL_O = abe_reg[`ABMC_ABE_DIG_OE];
  assign TEST_PIN_DIG_O = abe_reg[`ABMC_ABE_DIG_OE] & dig_mux;
  assign TEST_PIN_ANA_SEL_O = abe_reg[`ABMC_ABE_ANA_OE]
                              & ~abe_reg[`ABMC_ABE_DIG_OE];
  assign ANA_TO_ADC_SEL_O = ~abe_reg[`ABMC_ABE_ANA_OE];

  // role decode; the reserved code behaves as no reference routing
  assign DEVICE_ROLE_O = role_reg[`ABMC_ROLE_HI:`ABMC_ROLE_LO];
  assign ROLE_RESERVED_O = (role == ABMC_ROLE_RSVD);
  assign REF2_TO_PIN_O = (role == ABMC_ROLE_MASTER);
  assign FEEDBACK_TO_EXT_PIN_O = role_reg[`ABMC_ROLE_RFB];

  // a write to the enable register shows on the lockout and amplifier disable controls next cycle
  property p_abe_write;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      CLK_EN_I && WR_I && ADDR_I == `ABMC_ADDR_ABE |=>
        DRIVER_LOCKOUT_HIGH_O == $past(WDATA_I[`ABMC_ABE_UVLO_SEL])
        && ERROR_AMP_DISABLE_O == $past(WDATA_I[`ABMC_ABE_EA_DIS]);
  endproperty
  a_abe_write: assert property (p_abe_write)
    else $error("lockout or amp disable did not follow write");

  property p_after_reset;
    @(posedge CORE_CLK_I)
      !RST_N_I |=> !DRIVER_LOCKOUT_HIGH_O && !ERROR_AMP_DISABLE_O && !REF2_TO_PIN_O;
  endproperty
  a_after_reset: assert property (p_after_reset)
    else $error("controls not cleared after reset");

  property p_unused_bit;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      CLK_EN_I && RD_I && ADDR_I == `ABMC_ADDR_ABE |=>
        (RDATA_O & ~`ABMC_ABE_WMASK) == `ABMC_RESET_VAL;
  endproperty
  a_unused_bit: assert property (p_unused_bit)
    else $error("unused enable bit read as one");

  sequence s_wr_abe;
    CLK_EN_I && WR_I && ADDR_I == `ABMC_ADDR_ABE;
  endsequence
  sequence s_rd_abe;
    CLK_EN_I && RD_I && ADDR_I == `ABMC_ADDR_ABE;
  endsequence
  property p_readback;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      s_wr_abe ##1 s_rd_abe |=> RDATA_O == ($past(WDATA_I, 2) & `ABMC_ABE_WMASK);
  endproperty
  a_readback: assert property (p_readback)
    else $error("enable register read back wrong");

  property p_digital_wins;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      TEST_PIN_DIG_SEL_O |-> !TEST_PIN_ANA_SEL_O;
  endproperty
  a_digital_wins: assert property (p_digital_wins)
    else $error("analog and digital share test pin");

  property p_analog_pin;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      CLK_EN_I && WR_I && ADDR_I == `ABMC_ADDR_ABE && WDATA_I[7:0] == 8'h01 |=>
        TEST_PIN_ANA_SEL_O && !ANA_TO_ADC_SEL_O && !TEST_PIN_DIG_SEL_O;
  endproperty
  a_analog_pin: assert property (p_analog_pin)
    else $error("analog path not on test pin");

  property p_dig_select;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      TEST_PIN_DIG_SEL_O && digital_test_select == ABMC_DIGITAL_TEST_SELECT_OV
        |-> TEST_PIN_DIG_O == EXCESS_VOLTAGE_COMPARE_OUT_I;
  endproperty
  a_dig_select: assert property (p_dig_select)
    else $error("digital mux picked wrong source");

  property p_role;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      CLK_EN_I && WR_I && ADDR_I == `ABMC_ADDR_ROLE |=>
        REF2_TO_PIN_O == ($past(WDATA_I[`ABMC_ROLE_HI:`ABMC_ROLE_LO]) == ABMC_ROLE_MASTER)
        && FEEDBACK_TO_EXT_PIN_O == $past(WDATA_I[`ABMC_ROLE_RFB]);
  endproperty
  a_role: assert property (p_role)
    else $error("role or feedback route did not follow write");

  // read port; stale data would look like a second read to software
  property p_rdata_idle;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      CLK_EN_I && !RD_I |=> RDATA_O == `ABMC_RESET_VAL;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared after read cycle");

  property p_unused_role;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      CLK_EN_I && RD_I && ADDR_I == `ABMC_ADDR_ROLE |=>
        (RDATA_O & ~`ABMC_ROLE_WMASK) == `ABMC_RESET_VAL;
  endproperty
  a_unused_role: assert property (p_unused_role)
    else $error("unused role bits read as one");

  sequence s_wr_role;
    CLK_EN_I && WR_I && ADDR_I == `ABMC_ADDR_ROLE;
  endsequence
  sequence s_rd_role;
    CLK_EN_I && RD_I && ADDR_I == `ABMC_ADDR_ROLE;
  endsequence
  property p_role_readback;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      s_wr_role ##1 s_rd_role |=> RDATA_O == ($past(WDATA_I, 2) & `ABMC_ROLE_WMASK);
  endproperty
  a_role_readback: assert property (p_role_readback)
    else $error("role register read back wrong");

  // enable low freezes all state; without a write neither register may move
  property p_freeze;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      !CLK_EN_I |=> $stable(abe_reg) && $stable(role_reg) && $stable(RDATA_O);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_abe_hold;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      !(CLK_EN_I && WR_I && ADDR_I == `ABMC_ADDR_ABE) |=> $stable(abe_reg);
  endproperty
  a_abe_hold: assert property (p_abe_hold)
    else $error("enable register changed without a write");

  property p_role_hold;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      !(CLK_EN_I && WR_I && ADDR_I == `ABMC_ADDR_ROLE) |=> $stable(role_reg);
  endproperty
  a_role_hold: assert property (p_role_hold)
    else $error("role register changed without a write");

  // digital mux, every code except 4 (see a_dig_select); the pin must stay quiet when not enabled
  property p_dig_off;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      !TEST_PIN_DIG_SEL_O |-> !TEST_PIN_DIG_O;
  endproperty
  a_dig_off: assert property (p_dig_off)
    else $error("digital test signal leaks while disabled");

  property p_dig_none;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      TEST_PIN_DIG_SEL_O && digital_test_select == ABMC_DIGITAL_TEST_SELECT_NONE |-> !TEST_PIN_DIG_O;
  endproperty
  a_dig_none: assert property (p_dig_none)
    else $error("empty digital code drove the pin");

  property p_dig_sat;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      TEST_PIN_DIG_SEL_O && digital_test_select == ABMC_DIGITAL_TEST_SELECT_SAT |-> TEST_PIN_DIG_O == SAT_DETECT_I;
  endproperty
  a_dig_sat: assert property (p_dig_sat)
    else $error("digital code 0 picked wrong source");

  property p_dig_mono;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      TEST_PIN_DIG_SEL_O && digital_test_select == ABMC_DIGITAL_TEST_SELECT_MONO |-> TEST_PIN_DIG_O == MONO_PULSE_I;
  endproperty
  a_dig_mono: assert property (p_dig_mono)
    else $error("digital code 1 picked wrong source");

  property p_dig_osc;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      TEST_PIN_DIG_SEL_O && digital_test_select == ABMC_DIGITAL_TEST_SELECT_OSC |-> TEST_PIN_DIG_O == OSC_PULSE_I;
  endproperty
  a_dig_osc: assert property (p_dig_osc)
    else $error("digital code 2 picked wrong source");

  property p_dig_tmr2;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      TEST_PIN_DIG_SEL_O && digital_test_select == ABMC_DIGITAL_TEST_SELECT_TMR2
        |-> TEST_PIN_DIG_O == TIMER_TWO_PERIOD_MATCH_I;
  endproperty
  a_dig_tmr2: assert property (p_dig_tmr2)
    else $error("digital code 3 picked wrong source");

  property p_dig_switching_frequency_signal;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      TEST_PIN_DIG_SEL_O && digital_test_select == ABMC_DIGITAL_TEST_SELECT_SWITCHING_FREQUENCY_SIGNAL
        |-> TEST_PIN_DIG_O == SWITCHING_FREQUENCY_SIGNAL_I;
  endproperty
  a_dig_switching_frequency_signal: assert property (p_dig_switching_frequency_signal)
    else $error("digital code 5 picked wrong source");

  property p_dig_shot;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      TEST_PIN_DIG_SEL_O && digital_test_select == ABMC_DIGITAL_TEST_SELECT_SHOT
        |-> TEST_PIN_DIG_O == SECONDARY_DRIVE_PULSE_ONESHOT_I;
  endproperty
  a_dig_shot: assert property (p_dig_shot)
    else $error("digital code 6 picked wrong source");

  // analog signal has one home at a time; role decode drives the reference
  property p_ana_exclusive;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      ANA_TO_ADC_SEL_O |-> !TEST_PIN_ANA_SEL_O;
  endproperty
  a_ana_exclusive: assert property (p_ana_exclusive)
    else $error("analog signal on converter and test pin");

  property p_ref2;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      REF2_TO_PIN_O == (DEVICE_ROLE_O == ABMC_ROLE_MASTER);
  endproperty
  a_ref2: assert property (p_ref2)
    else $error("reference routing does not match role");

  property p_reserved;
    @(posedge CORE_CLK_I) disable iff (!RST_N_I)
      ROLE_RESERVED_O |-> DEVICE_ROLE_O == ABMC_ROLE_RSVD && !REF2_TO_PIN_O;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved role flagged wrongly");

endmodule : abmc_ctrl

// ===== pkg/abmc_regs.svh
`ifndef ABMC_REGS_SVH
`define ABMC_REGS_SVH
// register indices on the plain port
`define ABMC_ADDR_ABE 4'h0
`define ABMC_ADDR_ROLE 4'h1
// analog block enable control fields
`define ABMC_ABE_DIG_OE 7
`define ABMC_ABE_DIGITAL_TEST_SELECT_HI 6
`define ABMC_ABE_DIGITAL_TEST_SELECT_LO 4
`define ABMC_ABE_UVLO_SEL 3
`define ABMC_ABE_EA_DIS 1
`define ABMC_ABE_ANA_OE 0
`define ABMC_ABE_WMASK 8'hfb
// role and feedback route fields
`define ABMC_ROLE_HI 7
`define ABMC_ROLE_LO 6
`define ABMC_ROLE_RFB 5
`define ABMC_ROLE_WMASK 8'he0
`define ABMC_RESET_VAL 8'h00
`endif

// ===== pkg/abmc_pkg.sv
package abmc_pkg;
  typedef enum logic [1:0] {
    ABMC_ROLE_ALONE = 2'h0,
    ABMC_ROLE_MASTER = 2'h1,
    ABMC_ROLE_SLAVE = 2'h2,
    ABMC_ROLE_RSVD = 2'h3
  } abmc_role_e;
  typedef enum logic [2:0] {
    ABMC_DIGITAL_TEST_SELECT_SAT = 3'h0,
    ABMC_DIGITAL_TEST_SELECT_MONO = 3'h1,
    ABMC_DIGITAL_TEST_SELECT_OSC = 3'h2,
    ABMC_DIGITAL_TEST_SELECT_TMR2 = 3'h3,
    ABMC_DIGITAL_TEST_SELECT_OV = 3'h4,
    ABMC_DIGITAL_TEST_SELECT_SWITCHING_FREQUENCY_SIGNAL = 3'h5,
    ABMC_DIGITAL_TEST_SELECT_SHOT = 3'h6,
    ABMC_DIGITAL_TEST_SELECT_NONE = 3'h7
  } abmc_digital_test_select_e;
endpackage : abmc_pkg

// ===== tb/abmc_ctrl_tb_top.sv
`timescale 1ns/1ns
`include "abmc_regs.svh"
module abmc_ctrl_tb_top;
  logic CORE_CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic CLK_EN_I = 1'b1;
  logic [3:0] ADDR_I = 4'h0;
  logic [7:0] WDATA_I = 8'h00;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic [6:0] src = 7'h00;
  logic [7:0] RDATA_O;
  wire [10:0] outs;
  int n_fail = 0;
  int n_compared = 0;
  int m0 = 0;
  int m1 = 0;
  int exp_q[$];
  // free-running 20 MHz core clock
  always #25 CORE_CLK_I = ~CORE_CLK_I;
  abmc_ctrl i_dut (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .CLK_EN_I(CLK_EN_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .SAT_DETECT_I(src[0]), .MONO_PULSE_I(src[1]), .OSC_PULSE_I(src[2]),
    .TIMER_TWO_PERIOD_MATCH_I(src[3]), .EXCESS_VOLTAGE_COMPARE_OUT_I(src[4]),
    .SWITCHING_FREQUENCY_SIGNAL_I(src[5]), .SECONDARY_DRIVE_PULSE_ONESHOT_I(src[6]),
    .DRIVER_LOCKOUT_HIGH_O(outs[10]), .ERROR_AMP_DISABLE_O(outs[9]),
    .TEST_PIN_DIG_SEL_O(outs[8]), .TEST_PIN_DIG_O(outs[7]), .TEST_PIN_ANA_SEL_O(outs[6]),
    .ANA_TO_ADC_SEL_O(outs[5]), .DEVICE_ROLE_O(outs[4:3]), .ROLE_RESERVED_O(outs[2]),
    .REF2_TO_PIN_O(outs[1]), .FEEDBACK_TO_EXT_PIN_O(outs[0]));
  // model side of one access, applied once its strobe edge has passed
  task automatic upd(input bit w, input logic [3:0] a, input logic [7:0] d);
    if (w && CLK_EN_I && a == `ABMC_ADDR_ABE) m0 = d & 8'hfb;
    if (w && CLK_EN_I && a == `ABMC_ADDR_ROLE) m1 = d & 8'he0;
    if (!w) exp_q.push_back(a == 4'h0 ? m0 : (a == 4'h1 ? m1 : 0));
  endtask : upd
  // one bus access followed by an idle cycle
  task automatic acc(input bit w, input logic [3:0] a, input logic [7:0] d);
    @(posedge CORE_CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= w;
    RD_I <= !w;
    src <= 7'($urandom);
    @(posedge CORE_CLK_I);
    WR_I <= 1'b0;
    RD_I <= 1'b0;
    upd(w, a, d);
    @(negedge CORE_CLK_I);
  endtask : acc
  // write then read of one register with no gap between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
    @(posedge CORE_CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    src <= 7'($urandom);
    @(posedge CORE_CLK_I);
    WR_I <= 1'b0;
    RD_I <= 1'b1;
    upd(1'b1, a, d);
    @(posedge CORE_CLK_I);
    RD_I <= 1'b0;
    upd(1'b0, a, d);
    @(negedge CORE_CLK_I);
  endtask : wr_rd
  // decoded control outputs against the model registers
  task automatic check_out();
    logic [10:0] e;
    int c;
    c = (m0 >> 4) & 7;
    e = {m0[3], m0[1], m0[7], m0[7] && c < 7 && src[c], m0[0] && !m0[7], !m0[0],
      m1[7:6], m1[7:6] == 2'h3, m1[7:6] == 2'h1, m1[5]};
    n_compared++;
    if (outs !== e) begin
      n_fail++;
      $display("Error outputs expected %h seen %h", e, outs);
    end
  endtask : check_out
  // read data against the queued model value
  task automatic check_rd();
    logic [7:0] e;
    e = 8'(exp_q.pop_front());
    n_compared++;
    if (RDATA_O !== e) begin
      n_fail++;
      $display("Error read data expected %h seen %h", e, RDATA_O);
    end
  endtask : check_rd
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // watchdog sized well above the roughly 1100 cycles the tests take
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h1b6369f6));
    repeat (16) @(posedge CORE_CLK_I);
    RST_N_I <= 1'b1;
    @(negedge CORE_CLK_I);
    check_out();
    acc(0, 4'h0, 8'h00);
    check_rd();
    acc(0, 4'h1, 8'h00);
    check_rd();
    $display("test reset done");
    // every value of the enable register, random mux sources
    for (int i = 0; i < 256; i++) begin
      acc(1, 4'h0, i[7:0]);
      check_out();
      acc(0, 4'h0, 8'h00);
      check_rd();
    end
    $display("test enable register done");
    for (int i = 0; i < 8; i++) begin
      acc(1, 4'h1, {i[2:0], 5'h1f});
      check_out();
      acc(0, 4'h1, 8'h00);
      check_rd();
    end
    $display("test role register done");
    // write then read with no idle cycle, alternating registers
    for (int i = 0; i < 8; i++) begin
      wr_rd(i[0] ? 4'h1 : 4'h0, 8'($urandom));
      check_out();
      check_rd();
    end
    $display("test back to back done");
    // unmapped index, then a write of changed data with the clock enable low
    acc(1, 4'h2, 8'($urandom));
    check_out();
    acc(0, 4'h2, 8'h00);
    check_rd();
    @(posedge CORE_CLK_I);
    CLK_EN_I <= 1'b0;
    acc(1, 4'h0, 8'(~m0));
    @(posedge CORE_CLK_I);
    CLK_EN_I <= 1'b1;
    @(negedge CORE_CLK_I);
    check_out();
    acc(0, 4'h0, 8'h00);
    check_rd();
    $display("test refused access done");
    // second reset in mid-run clears both registers
    @(posedge CORE_CLK_I);
    RST_N_I <= 1'b0;
    repeat (2) @(posedge CORE_CLK_I);
    RST_N_I <= 1'b1;
    m0 = 0;
    m1 = 0;
    @(negedge CORE_CLK_I);
    check_out();
    acc(0, 4'h1, 8'h00);
    check_rd();
    $display("test second reset done");
    report_and_stop();
  end
endmodule : abmc_ctrl_tb_top
